// [rtl/dram_ctl_pkg.sv]
// constants and carrier types for the page-mode dram controller
package dram_ctl_pkg;
	localparam int unsigned CLK_MHZ        = 250;
	localparam int unsigned ADDR_BITS      = 18;
	localparam int unsigned HALF_BITS      = 9;
	localparam int unsigned DATA_BITS      = 16;
	localparam int unsigned BYTE_BITS      = 8;
	// times in ns, slowest grade; refresh and pause in us
	localparam int unsigned ROW_ACTIVE_NS  = 60;
	localparam int unsigned ROW_PRECHG_NS  = 40;
	localparam int unsigned COL_PRECHG_NS  = 10;
	localparam int unsigned COL_ACTIVE_NS  = 15;
	localparam int unsigned ROW_COL_NS     = 20;
	localparam int unsigned CYCLE_NS       = 110;
	localparam int unsigned SELF_ENTRY_NS  = 100000;
	localparam int unsigned SELF_EXIT_NS   = 130;
	localparam int unsigned PAUSE_US       = 200;
	localparam int unsigned REFRESH_US     = 8000;
	localparam int unsigned ROWS           = 512;
	localparam int unsigned WAKE_CYCLES    = 8;
	// ceil(ns*MHz/1000)
	localparam int unsigned T_RAS  = (ROW_ACTIVE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned T_RP   = (ROW_PRECHG_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned T_CP   = (COL_PRECHG_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned T_CAS  = (COL_ACTIVE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned T_RCD  = (ROW_COL_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned T_RC   = (CYCLE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned T_RASS = (SELF_ENTRY_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned T_RPS  = (SELF_EXIT_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned T_PAUSE = PAUSE_US * CLK_MHZ;
	// one refresh per row slot, rounded down
	localparam int unsigned T_REF_SLOT = (REFRESH_US * CLK_MHZ) / ROWS;

	typedef enum logic [1:0] {
		OP_READ,
		OP_WRITE,
		OP_REFRESH,
		OP_SELF
	} op_t;

	typedef struct packed {
		op_t                   op;
		logic [ADDR_BITS-1:0]  addr;
		logic [1:0]            byte_en;
		logic [DATA_BITS-1:0]  wdata;
	} req_t;

	typedef struct packed {
		logic                  row_strobe_n;
		logic                  lower_col_strobe_n;
		logic                  upper_col_strobe_n;
		logic                  write_strobe_n;
		logic                  out_gate_n;
		logic [HALF_BITS-1:0]  mux_addr;
	} pins_t;
endpackage : dram_ctl_pkg

// [rtl/dram_ctl.sv]
// controller that drives a 256k x 16 fast page mode dram over its pins
`timescale 1ns/1ps
`default_nettype none
module dram_ctl #(
	parameter int unsigned PAUSE_CYC = dram_ctl_pkg::T_PAUSE,
	parameter int unsigned SLOT_CYC  = dram_ctl_pkg::T_REF_SLOT,
	parameter int unsigned ENTRY_CYC = dram_ctl_pkg::T_RASS
) (
	// clock and reset
	input  wire logic                           clk_sys,
	input  wire logic                           rst_n,
	// request side
	input  wire logic                           req_valid,
	input  wire dram_ctl_pkg::req_t             req,
	input  wire logic                           self_exit,
	output var  logic                           req_ready_ff,
	output var  logic                           rsp_valid_ff,
	output var  logic [dram_ctl_pkg::DATA_BITS-1:0] rsp_data_ff,
	output var  logic                           in_self_ff,
	output var  logic                           init_done_ff,
	// dram pins
	output var  dram_ctl_pkg::pins_t            pins_ff,
	input  wire logic [dram_ctl_pkg::DATA_BITS-1:0] data_lines_in,
	output var  logic [dram_ctl_pkg::DATA_BITS-1:0] data_lines_out_ff,
	output var  logic [1:0]                     data_lines_oe_ff
);
	localparam int unsigned CW = 32;
	localparam int unsigned RW = $clog2(dram_ctl_pkg::ROWS);
	localparam int unsigned BB = dram_ctl_pkg::BYTE_BITS;

	typedef enum logic [3:0] {
		ST_PAUSE,
		ST_IDLE,
		ST_ROW,
		ST_COL,
		ST_CBR_SETUP,
		ST_CBR_ROW,
		ST_SELF,
		ST_HOLD,
		ST_PRECHG
	} state_t;

	state_t                   state_ff, nxt_state;
	logic [CW-1:0]            cnt_ff, nxt_cnt;
	logic [CW-1:0]            ras_cnt_ff, nxt_ras_cnt;
	logic [CW-1:0]            slot_ff, nxt_slot;
	logic [3:0]               wake_ff, nxt_wake;
	logic                     ref_due_ff, nxt_ref_due;
	logic                     overdue_ff, nxt_overdue;
	logic [RW-1:0]            row_ctr_ff, nxt_row_ctr;
	dram_ctl_pkg::req_t       cur_ff, nxt_cur;
	dram_ctl_pkg::pins_t      nxt_pins;
	logic [dram_ctl_pkg::DATA_BITS-1:0] nxt_dout, nxt_rdata;
	logic [1:0]               nxt_oe;
	logic                     nxt_ready, nxt_rsp, nxt_self, nxt_init;

	function automatic logic [dram_ctl_pkg::DATA_BITS-1:0] lane_merge(
		input logic [dram_ctl_pkg::DATA_BITS-1:0] old_v,
		input logic [dram_ctl_pkg::DATA_BITS-1:0] new_v,
		input logic [1:0]                         en
	);
		logic [dram_ctl_pkg::DATA_BITS-1:0] r;
		r = old_v;
		if (en[0])
		begin
			r[BB-1:0] = new_v[BB-1:0];
		end
		if (en[1])
		begin
			r[2*BB-1:BB] = new_v[2*BB-1:BB];
		end
		return r;
	endfunction : lane_merge

	function automatic dram_ctl_pkg::pins_t idle_pins();
		dram_ctl_pkg::pins_t p;
		p.row_strobe_n       = 1'b1;
		p.lower_col_strobe_n = 1'b1;
		p.upper_col_strobe_n = 1'b1;
		p.write_strobe_n     = 1'b1;
		p.out_gate_n         = 1'b1;
		p.mux_addr           = '0;
		return p;
	endfunction : idle_pins

	// refresh slot timer and overdue watch
	always_comb
	begin
		nxt_slot    = slot_ff + CW'(1);
		nxt_ref_due = ref_due_ff;
		nxt_overdue = overdue_ff;
		// clears come first so that a slot tick in the same cycle wins
		if (state_ff == ST_CBR_ROW && cnt_ff == '0)
		begin
			nxt_ref_due = 1'b0;
		end
		if (wake_ff != 4'h0)
		begin
			nxt_overdue = 1'b0;
		end
		if (slot_ff >= CW'(SLOT_CYC - 1))
		begin
			nxt_slot = '0;
			if (ref_due_ff && !in_self_ff && state_ff != ST_PAUSE)
			begin
				nxt_overdue = 1'b1;
			end
			nxt_ref_due = 1'b1;
		end
		// the device refreshes itself from self refresh entry onwards
		if (state_ff == ST_PAUSE || in_self_ff)
		begin
			nxt_ref_due = 1'b0;
		end
		if (state_ff == ST_PAUSE)
		begin
			nxt_overdue = 1'b0;
		end
	end

	// main sequencer
	always_comb
	begin
		nxt_state   = state_ff;
		nxt_cnt     = (cnt_ff != '0) ? cnt_ff - CW'(1) : cnt_ff;
		nxt_ras_cnt = (ras_cnt_ff != '0) ? ras_cnt_ff - CW'(1) : ras_cnt_ff;
		nxt_wake    = wake_ff;
		nxt_row_ctr = row_ctr_ff;
		nxt_cur     = cur_ff;
		nxt_pins    = pins_ff;
		nxt_dout    = data_lines_out_ff;
		nxt_oe      = data_lines_oe_ff;
		nxt_rdata   = rsp_data_ff;
		nxt_ready   = 1'b0;
		nxt_rsp     = 1'b0;
		nxt_self    = in_self_ff;
		nxt_init    = init_done_ff;
		case (state_ff)
			ST_PAUSE:
			begin
				nxt_pins = idle_pins();
				nxt_oe   = 2'b00;
				if (cnt_ff == '0)
				begin
					nxt_wake  = 4'(dram_ctl_pkg::WAKE_CYCLES);
					nxt_state = ST_CBR_SETUP;
					nxt_cnt   = CW'(dram_ctl_pkg::T_RP);
				end
			end
			ST_IDLE:
			begin
				// a request seen with ready high is never dropped for a refresh, except OP_SELF, which becomes a plain refresh if one is due
				if (req_valid && req_ready_ff)
				begin
					nxt_cur = req;
					if (req.op == dram_ctl_pkg::OP_REFRESH ||
					    req.op == dram_ctl_pkg::OP_SELF)
					begin
						nxt_state = ST_CBR_SETUP;
					end
					else
					begin
						// row half first, row strobe opens the cycle
						nxt_pins.mux_addr = req.addr[dram_ctl_pkg::ADDR_BITS-1:
							dram_ctl_pkg::HALF_BITS];
						nxt_state   = ST_ROW;
						nxt_cnt     = CW'(1);
						nxt_ras_cnt = CW'(dram_ctl_pkg::T_RC);
					end
				end
				else if (overdue_ff)
				begin
					// internal refreshes answer nobody and never enter self
					nxt_cur   = '0;
					nxt_wake  = 4'(dram_ctl_pkg::WAKE_CYCLES);
					nxt_state = ST_CBR_SETUP;
				end
				else if (ref_due_ff)
				begin
					nxt_cur   = '0;
					nxt_state = ST_CBR_SETUP;
				end
				else
				begin
					nxt_ready = 1'b1;
				end
			end
			ST_ROW:
			begin
				if (pins_ff.row_strobe_n)
				begin
					nxt_pins.row_strobe_n = 1'b0;
					nxt_ras_cnt = CW'(dram_ctl_pkg::T_RAS);
					nxt_cnt     = CW'(dram_ctl_pkg::T_RCD);
				end
				else if (cnt_ff == '0)
				begin
					nxt_pins.mux_addr = cur_ff.addr[dram_ctl_pkg::HALF_BITS-1:0];
					if (cur_ff.op == dram_ctl_pkg::OP_WRITE)
					begin
						nxt_pins.write_strobe_n = 1'b0;
						nxt_dout = cur_ff.wdata;
						nxt_oe   = cur_ff.byte_en;
					end
					else
					begin
						nxt_pins.write_strobe_n = 1'b1;
						nxt_pins.out_gate_n     = 1'b0;
					end
					nxt_cnt   = CW'(1);
					nxt_state = ST_COL;
				end
			end
			ST_COL:
			begin
				// no lane enabled: no column strobe, the row is just closed
				if (!pins_ff.lower_col_strobe_n || !pins_ff.upper_col_strobe_n ||
				    cur_ff.byte_en == 2'b00)
				begin
					// access window: data sampled only at the end
					if (cnt_ff == '0 && ras_cnt_ff == '0)
					begin
						if (cur_ff.op == dram_ctl_pkg::OP_READ)
						begin
							nxt_rdata = lane_merge('0, data_lines_in,
								cur_ff.byte_en);
							nxt_rsp = 1'b1;
						end
						nxt_pins = idle_pins();
						nxt_oe   = 2'b00;
						nxt_state = ST_PRECHG;
						nxt_cnt   = CW'(dram_ctl_pkg::T_RP);
					end
				end
				else if (cnt_ff == '0)
				begin
					// column half is stable two cycles before the strobe
					nxt_pins.lower_col_strobe_n = ~cur_ff.byte_en[0];
					nxt_pins.upper_col_strobe_n = ~cur_ff.byte_en[1];
					nxt_cnt = CW'(dram_ctl_pkg::T_CAS);
				end
			end
			ST_CBR_SETUP:
			begin
				nxt_pins = idle_pins();
				nxt_oe   = 2'b00;
				if (cnt_ff == '0 && ras_cnt_ff == '0)
				begin
					nxt_pins.lower_col_strobe_n = 1'b0;
					nxt_pins.upper_col_strobe_n = 1'b0;
					nxt_cnt   = CW'(1);
					nxt_state = ST_CBR_ROW;
				end
			end
			ST_CBR_ROW:
			begin
				if (pins_ff.row_strobe_n && cnt_ff == '0)
				begin
					nxt_pins.row_strobe_n = 1'b0;
					nxt_cnt = CW'(dram_ctl_pkg::T_RAS);
					// decided once here: a slot tick during the long entry
					// hold must not turn it back into a plain refresh
					if (cur_ff.op == dram_ctl_pkg::OP_SELF && init_done_ff &&
					    !ref_due_ff && !overdue_ff)
					begin
						nxt_self = 1'b1;
						nxt_cnt  = CW'(ENTRY_CYC);
					end
				end
				else if (!pins_ff.row_strobe_n && cnt_ff == '0)
				begin
					nxt_row_ctr = row_ctr_ff + RW'(1);
					if (in_self_ff)
					begin
						nxt_state = ST_SELF;
					end
					else
					begin
						nxt_pins = idle_pins();
						nxt_cnt  = CW'(dram_ctl_pkg::T_RP);
						nxt_state = ST_PRECHG;
						if (wake_ff != 4'h0)
						begin
							nxt_wake = wake_ff - 4'h1;
						end
						if (cur_ff.op == dram_ctl_pkg::OP_REFRESH && init_done_ff
						    && wake_ff == 4'h0)
						begin
							nxt_rsp = 1'b1;
						end
					end
				end
			end
			ST_SELF:
			begin
				if (self_exit)
				begin
					nxt_pins  = idle_pins();
					nxt_cnt   = CW'(dram_ctl_pkg::T_RPS);
					nxt_state = ST_HOLD;
				end
			end
			ST_HOLD:
			begin
				if (cnt_ff == '0)
				begin
					nxt_self  = 1'b0;
					nxt_rsp   = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			ST_PRECHG:
			begin
				if (cnt_ff == '0 && ras_cnt_ff == '0)
				begin
					if (wake_ff != 4'h0)
					begin
						nxt_cnt   = CW'(dram_ctl_pkg::T_CP);
						nxt_state = ST_CBR_SETUP;
					end
					else
					begin
						nxt_init  = 1'b1;
						nxt_state = ST_IDLE;
					end
				end
			end
			default:
			begin
				nxt_state = ST_PAUSE;
			end
		endcase
		// one column access per row opening keeps page count at 1
		// column strobes are high before every row strobe fall here except the CBR refresh ones, where they fall first
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			slot_ff    <= '0;
			ref_due_ff <= 1'b0;
			overdue_ff <= 1'b0;
		end
		else
		begin
			slot_ff    <= nxt_slot;
			ref_due_ff <= nxt_ref_due;
			overdue_ff <= nxt_overdue;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff          <= ST_PAUSE;
			cnt_ff            <= CW'(PAUSE_CYC);
			ras_cnt_ff        <= '0;
			wake_ff           <= 4'h0;
			row_ctr_ff        <= '0;
			cur_ff            <= '0;
			pins_ff           <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, '0};
			data_lines_out_ff <= '0;
			data_lines_oe_ff  <= 2'b00;
			rsp_data_ff       <= '0;
			req_ready_ff      <= 1'b0;
			rsp_valid_ff      <= 1'b0;
			in_self_ff        <= 1'b0;
			init_done_ff      <= 1'b0;
		end
		else
		begin
			state_ff          <= nxt_state;
			cnt_ff            <= nxt_cnt;
			ras_cnt_ff        <= nxt_ras_cnt;
			wake_ff           <= nxt_wake;
			row_ctr_ff        <= nxt_row_ctr;
			cur_ff            <= nxt_cur;
			pins_ff           <= nxt_pins;
			data_lines_out_ff <= nxt_dout;
			data_lines_oe_ff  <= nxt_oe;
			rsp_data_ff       <= nxt_rdata;
			req_ready_ff      <= nxt_ready;
			rsp_valid_ff      <= nxt_rsp;
			in_self_ff        <= nxt_self;
			init_done_ff      <= nxt_init;
		end
	end
endmodule : dram_ctl
`default_nettype wire

// [tb/dram_ctl_monitor.sv]
// assertions on the pins and handshake of the dram controller
`timescale 1ns/1ps
`default_nettype none
module dram_ctl_monitor (
	// clock and reset
	input wire logic                clk_sys,
	input wire logic                rst_n,
	// request side
	input wire logic                req_valid,
	input wire dram_ctl_pkg::req_t  req,
	input wire logic                self_exit,
	input wire logic                req_ready_ff,
	input wire logic                rsp_valid_ff,
	input wire logic [15:0]         rsp_data_ff,
	input wire logic                in_self_ff,
	input wire logic                init_done_ff,
	// dram pins
	input wire dram_ctl_pkg::pins_t pins_ff,
	input wire logic [15:0]         data_lines_in,
	input wire logic [15:0]         data_lines_out_ff,
	input wire logic [1:0]          data_lines_oe_ff
);
	logic               row_n;
	logic               col_n;
	logic               we_n;
	logic [15:0]        lane_mask;
	logic [19:0]        lo_ff;
	logic [19:0]        hi_ff;
	dram_ctl_pkg::req_t tk_ff;
	assign row_n = pins_ff.row_strobe_n;
	assign col_n = pins_ff.lower_col_strobe_n & pins_ff.upper_col_strobe_n;
	assign we_n = pins_ff.write_strobe_n;
	assign lane_mask = {{8{tk_ff.byte_en[1]}}, {8{tk_ff.byte_en[0]}}};
	// run lengths of the row strobe and the last request taken
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lo_ff <= '0;
			hi_ff <= '0;
			tk_ff <= '0;
		end
		else
		begin
			lo_ff <= row_n ? '0 : lo_ff + 20'h1;
			hi_ff <= row_n ? hi_ff + 20'h1 : '0;
			if (req_valid && req_ready_ff)
				tk_ff <= req;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_take;
		req_valid && req_ready_ff;
	endsequence
	sequence s_row_open;
		$fell(row_n) && col_n;
	endsequence
	sequence s_cbr;
		$fell(row_n) && !col_n;
	endsequence
	sequence s_col_open;
		$fell(col_n) && !row_n;
	endsequence
	init_gate_a: assert property (
		!init_done_ff |-> !req_ready_ff) else $error("ready before init");
	busy_hold_a: assert property (
		s_take |=> !req_ready_ff [*8]) else $error("ready too soon");
	row_addr_a: assert property (
		s_row_open |-> pins_ff.mux_addr == tk_ff.addr[17:9])
		else $error("bad row half");
	col_addr_a: assert property (
		s_col_open |-> pins_ff.mux_addr == tk_ff.addr[8:0])
		else $error("bad column half");
	byte_lane_a: assert property (
		s_col_open |-> {pins_ff.upper_col_strobe_n,
		pins_ff.lower_col_strobe_n} == ~tk_ff.byte_en)
		else $error("bad lane strobes");
	read_cmd_a: assert property (
		s_col_open and tk_ff.op == dram_ctl_pkg::OP_READ
		|-> we_n && !pins_ff.out_gate_n) else $error("bad read command");
	early_write_a: assert property (
		s_col_open and !we_n |-> !$past(we_n) && data_lines_oe_ff ==
		tk_ff.byte_en && ((data_lines_out_ff ^ tk_ff.wdata) & lane_mask)
		== 16'h0) else $error("bad write data");
	col_hold_a: assert property (
		!row_n && !col_n && $past(!row_n && !col_n)
		|-> $stable(pins_ff.mux_addr)) else $error("column moved");
	no_drive_a: assert property (
		we_n |-> data_lines_oe_ff == 2'h0) else $error("drive in read");
	cbr_form_a: assert property (
		s_cbr |-> !pins_ff.lower_col_strobe_n &&
		!pins_ff.upper_col_strobe_n && data_lines_oe_ff == 2'h0)
		else $error("bad refresh form");
	ras_width_a: assert property (
		$rose(row_n) |-> lo_ff >= dram_ctl_pkg::T_RAS)
		else $error("row strobe too short");
	precharge_a: assert property (
		$fell(row_n) |-> hi_ff >= dram_ctl_pkg::T_RP)
		else $error("precharge too short");
	exit_hold_a: assert property (
		$fell(in_self_ff) |-> row_n && hi_ff >= dram_ctl_pkg::T_RPS - 1)
		else $error("self exit too short");
endmodule : dram_ctl_monitor
bind dram_ctl dram_ctl_monitor u_dram_ctl_monitor (
	.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req(req),
	.self_exit(self_exit), .req_ready_ff(req_ready_ff),
	.rsp_valid_ff(rsp_valid_ff), .rsp_data_ff(rsp_data_ff),
	.in_self_ff(in_self_ff), .init_done_ff(init_done_ff), .pins_ff(pins_ff),
	.data_lines_in(data_lines_in), .data_lines_out_ff(data_lines_out_ff),
	.data_lines_oe_ff(data_lines_oe_ff));
`default_nettype wire

// [tb/dram_model.sv]
// behavioural model of the page-mode dram seen from its pins
`timescale 1ns/1ps
`default_nettype none
module dram_model #(
	parameter int ROW_ACC = 15,
	parameter int COL_ACC = 4
) (
	input  wire logic                clk_sys,
	input  wire dram_ctl_pkg::pins_t pins,
	input  wire logic [15:0]         data_lines_out,
	input  wire logic [1:0]          oe,
	output var  logic [15:0]         data_lines_in
);
	logic [15:0] mem [bit [17:0]]; // never decays
	logic [8:0]  row_q;
	logic [8:0]  col_q;
	logic        cbr_q = 1'b1;
	logic        col_n;
	logic        rd_ok;
	logic [15:0] last_q = 16'h0;
	logic [15:0] held_q = 16'h0;
	logic        hid_ok;
	logic [15:0] word;
	int          row_cyc = 0;
	int          col_cyc = 0;
	assign col_n = pins.lower_col_strobe_n & pins.upper_col_strobe_n;
	always @(negedge pins.row_strobe_n)
	begin
		cbr_q = !col_n;
		row_q = pins.mux_addr;
	end
	always @(negedge col_n)
		col_q = pins.mux_addr;
	task automatic put(input int l);
		logic [17:0] a;
		logic [15:0] w;
		a = {row_q, pins.mux_addr};
		w = mem.exists(a) ? mem[a] : 16'h0;
		// a lane the controller does not drive stores garbage
		w[l*8 +: 8] = oe[l] ? data_lines_out[l*8 +: 8] : ~data_lines_out[l*8 +: 8];
		mem[a] = w;
	endtask : put
	always @(negedge pins.lower_col_strobe_n)
		if (!pins.row_strobe_n && !cbr_q && !pins.write_strobe_n)
			put(0);
	always @(negedge pins.upper_col_strobe_n)
		if (!pins.row_strobe_n && !cbr_q && !pins.write_strobe_n)
			put(1);
	always @(posedge clk_sys)
	begin
		row_cyc <= pins.row_strobe_n ? 0 : row_cyc + 1;
		col_cyc <= col_n ? 0 : col_cyc + 1;
		last_q <= data_lines_in;
		if (rd_ok)
			held_q <= word;
	end
	// released lanes toggle every cycle instead of holding the last value
	always @*
	begin
		word = mem.exists({row_q, col_q}) ? mem[{row_q, col_q}] : 16'h0;
		rd_ok = !pins.row_strobe_n && !col_n && !cbr_q && pins.write_strobe_n
			&& !pins.out_gate_n && row_cyc >= ROW_ACC && col_cyc >= COL_ACC;
		// column strobe low at row fall keeps the last read word out
		hid_ok = cbr_q && !pins.row_strobe_n && pins.write_strobe_n &&
			!pins.out_gate_n;
		data_lines_in[7:0] = (rd_ok && !pins.lower_col_strobe_n) ? word[7:0] :
			(hid_ok && !pins.lower_col_strobe_n) ? held_q[7:0] :
			~last_q[7:0];
		data_lines_in[15:8] = (rd_ok && !pins.upper_col_strobe_n) ? word[15:8] :
			(hid_ok && !pins.upper_col_strobe_n) ? held_q[15:8] :
			~last_q[15:8];
	end
endmodule : dram_model
`default_nettype wire

// [tb/tb_dram_ctl.sv]
// self-checking bench for the dram controller against a behavioural device
`timescale 1ns/1ps
`default_nettype none
module tb_dram_ctl;
	localparam int PAUSE = 20;
	logic                clk_sys = 1'b0;
	logic                rst_n = 1'b0;
	logic                req_valid = 1'b0;
	logic                self_exit = 1'b0;
	dram_ctl_pkg::req_t  req = '0;
	logic                req_ready_ff, rsp_valid_ff, in_self_ff, init_done_ff;
	logic [15:0]         rsp_data_ff, data_lines_in, data_lines_out_ff;
	logic [1:0]          data_lines_oe_ff;
	dram_ctl_pkg::pins_t pins_ff;
	int                  n_errors = 0, samples_checked = 0, cyc = 0;
	int                  n_cbr = 0, n_wake = 0, t_first = 0, t_rel = 0;
	logic [15:0]         ref_mem [bit [17:0]];
	bit [17:0]           addr_q [$];
	dram_ctl #(.PAUSE_CYC(PAUSE), .SLOT_CYC(200), .ENTRY_CYC(30)) u_dram_ctl (
		.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req(req),
		.self_exit(self_exit), .req_ready_ff(req_ready_ff),
		.rsp_valid_ff(rsp_valid_ff), .rsp_data_ff(rsp_data_ff),
		.in_self_ff(in_self_ff), .init_done_ff(init_done_ff), .pins_ff(pins_ff),
		.data_lines_in(data_lines_in), .data_lines_out_ff(data_lines_out_ff),
		.data_lines_oe_ff(data_lines_oe_ff));
	dram_model u_dram_model (.clk_sys(clk_sys), .pins(pins_ff),
		.data_lines_out(data_lines_out_ff), .oe(data_lines_oe_ff),
		.data_lines_in(data_lines_in));
	initial forever #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;
	always @(negedge pins_ff.row_strobe_n)
		if (rst_n)
		begin
			n_cbr += int'(!pins_ff.lower_col_strobe_n || !pins_ff.upper_col_strobe_n);
			n_wake += int'(!init_done_ff);
			if (n_wake == 1 && !init_done_ff)
				t_first = cyc;
		end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test;
		$display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test
	function automatic logic flag(input int k);
		case (k)
			0: return req_ready_ff;
			1: return rsp_valid_ff;
			default: return init_done_ff;
		endcase
	endfunction : flag
	task automatic wait_hi(input int k);
		int i;
		for (i = 0; i < 3000 && flag(k) !== 1'b1; i++)
			@(negedge clk_sys);
		if (i == 3000)
		begin
			n_errors++;
			stop_test();
		end
	endtask : wait_hi
	task automatic issue(input dram_ctl_pkg::op_t o, input logic [17:0] a,
		input logic [1:0] be, input logic [15:0] d);
		@(negedge clk_sys);
		req_valid = 1'b1;
		req = '{op: o, addr: a, byte_en: be, wdata: d};
		wait_hi(0);
		@(negedge clk_sys);
		req_valid = 1'b0;
	endtask : issue
	task automatic wr(input logic [17:0] a, input logic [1:0] be,
		input logic [15:0] d);
		logic [15:0] w;
		w = ref_mem.exists(a) ? ref_mem[a] : 16'h0;
		if (be[0]) w[7:0] = d[7:0];
		if (be[1]) w[15:8] = d[15:8];
		ref_mem[a] = w;
		issue(dram_ctl_pkg::OP_WRITE, a, be, d);
	endtask : wr
	task automatic rd(input logic [17:0] a, input logic [1:0] be);
		logic [15:0] w;
		w = ref_mem.exists(a) ? ref_mem[a] : 16'h0;
		issue(dram_ctl_pkg::OP_READ, a, be, 16'h0);
		wait_hi(1);
		check(rsp_data_ff, w & {{8{be[1]}}, {8{be[0]}}});
	endtask : rd
	task automatic do_reset;
		// at the start reset is already low from time zero
		if (rst_n)
			@(negedge clk_sys);
		rst_n = 1'b0;
		n_wake = 0;
		@(negedge clk_sys);
		check({pins_ff[13:11], data_lines_oe_ff}, 5'h1C);
		repeat (3) @(negedge clk_sys);
		rst_n = 1'b1;
		t_rel = cyc;
		wait_hi(2);
		check(n_wake, 8);
		check(t_first - t_rel >= PAUSE, 1);
		$display("test reset and wake-up done");
	endtask : do_reset
	initial
	begin
		int k;
		logic [17:0] a;
		void'($urandom(32'hc116));
		do_reset();
		for (k = 0; k < 12; k++)
		begin
			a = (k == 0) ? 18'h0 : (k == 1) ? 18'h3FFFF : 18'($urandom);
			addr_q.push_back(a);
			wr(a, 2'(1 + k % 3), 16'($urandom));
		end
		foreach (addr_q[i])
			rd(addr_q[i], 2'(3 - i % 3));
		$display("test write and read done");
		k = n_cbr;
		issue(dram_ctl_pkg::OP_REFRESH, 18'h0, 2'h0, 16'h0);
		wait_hi(1);
		check(n_cbr > k, 1);
		k = n_cbr;
		repeat (800) @(negedge clk_sys);
		check(n_cbr - k >= 3, 1);
		$display("test refresh done");
		for (k = 0; k < 3 && in_self_ff !== 1'b1; k++)
		begin
			issue(dram_ctl_pkg::OP_SELF, 18'h0, 2'h0, 16'h0);
			for (int j = 0; j < 200 && !in_self_ff && !req_ready_ff; j++)
				@(negedge clk_sys);
		end
		check(in_self_ff, 1);
		repeat (60) @(negedge clk_sys);
		check(pins_ff.row_strobe_n, 0);
		self_exit = 1'b1;
		wait_hi(1);
		self_exit = 1'b0;
		@(negedge clk_sys);
		check(in_self_ff, 0);
		rd(addr_q[0], 2'h3);
		$display("test self refresh done");
		issue(dram_ctl_pkg::OP_READ, addr_q[1], 2'h3, 16'h0);
		repeat (4) @(negedge clk_sys);
		do_reset();
		rd(addr_q[1], 2'h3);
		$display("test reset in mid-cycle done");
		stop_test();
	end
	initial
	begin
		repeat (60000) @(posedge clk_sys);
		n_errors++;
		stop_test();
	end
endmodule : tb_dram_ctl
`default_nettype wire
